// ---- design/tlv_intr_unit.sv ----
// tlv_intr_unit: two-level, six-source vectored interrupt unit with an AHB-Lite slave
// assumes the core reports instruction end and the return instruction, and timer
// and serial units pulse their flag set events; one clock, async active-low reset
//
// Notes on behaviour
// [R1] one priority bit per source selects level
// [R2] reset clears priority select to low level
// [R3] low preempted only by high; high never
// [R4] higher level wins among simultaneous requests
// [R5] same level resolved by fixed polling order
// [R6] flags sampled at STATE5_PHASE2_SAMPLE_POINT, polled next cycle
// [R7] vectoring blocked by level, mid-instruction, register access
// [R8] one more instruction after return or access
// [R9] denied requests are never remembered
// [R10] call pushes program counter, not status word
// [R11] vectors 0003, 000B, 0013 for first three
// [R12] vectors 001B, 0023, 002B; reset at 0000
// [R13] vectoring clears timer 0 and 1 flags, external in edge
// [R14] return instruction ends current in-progress level
// [R15] plain return leaves in-progress level set
// [R16] level mode: sampled low pin sets request
// [R17] edge mode: high then low sample sets flag
// [R18] requester holds pin levels one machine cycle
// [R19] level requester holds until call, releases before
// [R20] serial and timer2 sources OR their flags
// [R21] per-source enable and global enable gate
// [R22] timer2 sampled at STATE2_PHASE2_POINT, polled same cycle
// [R23] one in-progress bit per priority level
`timescale 1ns/10ps
`default_nettype none

module tlv_intr_unit
    import tlv_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        ext0_pin,
    input  wire logic        ext1_pin,
    input  wire tlv_evt_s    flag_set,
    input  wire logic        instr_last_cycle,
    input  wire logic        isr_exit_instruction,
    input  wire logic        plain_subroutine_exit,
    output logic             hardware_subroutine_call,
    output tlv_call_s        call_info,
    output logic             cycle_end,
    output logic [1:0]       in_progress
);

    // machine-cycle phase counter
    logic [3:0] phase_reg;       // 0 .. PH_LAST
    wire  logic at_state5_phase2_sample_point;         // sample point of most flags
    wire  logic at_state2_phase2_point;         // sample point of timer 2
    wire  logic at_end;          // last clock of the machine cycle

    assign at_state5_phase2_sample_point = (phase_reg == PH_STATE5_PHASE2_SAMPLE_POINT);
    assign at_state2_phase2_point = (phase_reg == PH_STATE2_PHASE2_POINT);
    assign at_end  = (phase_reg == PH_LAST);

    // divider producing the phase enables
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            phase_reg <= 4'h0;
        else if (at_end)
            phase_reg <= 4'h0;
        else
            phase_reg <= phase_reg + 4'h1;

    // bus address phase decode
    wire logic       acc;        // valid word transfer taken this edge
    wire logic       ctl_acc;    // any access to enable or priority register
    logic            dph_wr_reg; // write pending in data phase
    logic [7:0]      dph_adr_reg;
    logic [7:0]      hrdata_reg;
    wire logic [7:0] wdata;
    wire logic       wr_tc;
    wire logic       wr_sc;
    wire logic       wr_t2;
    wire logic       wr_ie;
    wire logic       wr_ip;

    assign acc     = hsel && htrans[1] && hready && (hsize == 3'h2);
    assign ctl_acc = acc && ((haddr[7:0] == ADDR_INT_ENABLE) || (haddr[7:0] == ADDR_PRIORITY));
    assign wdata   = hwdata[7:0];
    assign wr_tc   = dph_wr_reg && (dph_adr_reg == ADDR_TIMER_CTRL);
    assign wr_sc   = dph_wr_reg && (dph_adr_reg == ADDR_SERIAL_CTRL);
    assign wr_t2   = dph_wr_reg && (dph_adr_reg == ADDR_TIMER2_CTRL);
    assign wr_ie   = dph_wr_reg && (dph_adr_reg == ADDR_INT_ENABLE);
    assign wr_ip   = dph_wr_reg && (dph_adr_reg == ADDR_PRIORITY);

    // zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = {24'h0, hrdata_reg};

    // control and flag registers
    logic [7:0] tc_reg;          // timer_control_reg
    logic [7:0] sc_reg;          // serial_control_reg
    logic [7:0] t2_reg;          // timer2_control_reg
    logic [7:0] ie_reg;          // interrupt_enable_reg
    logic [7:0] ip_reg;          // priority_select_reg
    logic [1:0] inprog_reg;      // in-progress bit per level
    logic       cur_blk_reg;     // current instruction blocks vectoring
    logic [1:0] pin_prev_reg;    // pin samples of the previous cycle
    logic [4:0] samp_reg;        // flags caught at STATE5_PHASE2_SAMPLE_POINT
    logic [5:0] poll_reg;        // values under poll this cycle
    logic       call_reg;
    tlv_call_s  info_reg;

    // read mux over the register map
    wire logic [7:0] stat;
    wire logic [7:0] rd_data;

    assign stat    = {2'h0, cur_blk_reg, info_reg.src, inprog_reg};
    assign rd_data = (haddr[7:0] == ADDR_TIMER_CTRL)  ? tc_reg :
                     (haddr[7:0] == ADDR_SERIAL_CTRL) ? sc_reg :
                     (haddr[7:0] == ADDR_TIMER2_CTRL) ? t2_reg :
                     (haddr[7:0] == ADDR_INT_ENABLE)  ? ie_reg :
                     (haddr[7:0] == ADDR_PRIORITY)    ? ip_reg :
                     (haddr[7:0] == ADDR_STATUS)      ? stat   : 8'h00;

    // capture the address phase and read data
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            dph_wr_reg  <= 1'b0;
            dph_adr_reg <= 8'h00;
            hrdata_reg  <= 8'h00;
        end
        else
        begin
            dph_wr_reg  <= acc && hwrite;
            dph_adr_reg <= haddr[7:0];
            if (acc && !hwrite)
                hrdata_reg <= rd_data;
        end

    // source flags and requests
    wire logic [5:0] src_flag;   // request per source in polling order
    wire logic [5:0] req;
    wire logic [5:0] hi_req;
    wire logic [5:0] lo_req;

    assign src_flag[SRC_EXT0] = tc_reg[TC_EXT0_FLAG];
    assign src_flag[SRC_T0]   = tc_reg[TC_TF0];
    assign src_flag[SRC_EXT1] = tc_reg[TC_EXT1_FLAG];
    assign src_flag[SRC_T1]   = tc_reg[TC_TF1];
    assign src_flag[SRC_SER]  = sc_reg[SC_RX] | sc_reg[SC_TX];    // R20
    assign src_flag[SRC_T2]   = t2_reg[T2_TF2] | t2_reg[T2_TIMER2_EXTERNAL_FLAG]; // R20

    // enable gating then split by level
    assign req    = poll_reg & ie_reg[5:0] & {6{ie_reg[IE_GLOBAL]}}; // R21 R9
    assign hi_req = req & ip_reg[5:0];  // R1
    assign lo_req = req & ~ip_reg[5:0]; // R1

    // fixed-order pick inside each level
    wire logic       hi_any;
    wire logic       lo_any;
    wire logic [2:0] hi_idx;
    wire logic [2:0] lo_idx;

    tlv_prio_pick #(.N(SRC_COUNT), .W(3)) u_pick_hi ( // R5
        .req (hi_req),
        .any (hi_any),
        .idx (hi_idx)
    );

    tlv_prio_pick #(.N(SRC_COUNT), .W(3)) u_pick_lo ( // R5
        .req (lo_req),
        .any (lo_any),
        .idx (lo_idx)
    );

    // vectoring decision at the end of the polling cycle
    wire logic       use_hi;
    wire logic       use_lo;
    wire logic       blk_evt;
    wire logic       take;
    wire logic [2:0] pick_src;

    assign use_hi   = hi_any && !inprog_reg[1];                        // R3 R4
    assign use_lo   = lo_any && !hi_any && (inprog_reg == 2'b00);      // R3 R4
    assign blk_evt  = isr_exit_instruction || ctl_acc;                 // R7
    assign take     = at_end && instr_last_cycle && !cur_blk_reg && !blk_evt
                      && (use_hi || use_lo);                           // R7
    assign pick_src = use_hi ? hi_idx : lo_idx;

    // vector address of a source
    function automatic logic [15:0] vec_of(input logic [2:0] s);
        vec_of = VEC_BASE + {10'h0, s, 3'h0};
    endfunction

    // external pins: edge or level detection
    wire logic [1:0] pin;
    wire logic [1:0] edge_sel;
    wire logic [1:0] ext_set;
    wire logic [1:0] ext_clr;

    assign pin      = {ext1_pin, ext0_pin};
    assign edge_sel = {tc_reg[TC_IT1], tc_reg[TC_IT0]};

    genvar e;
    generate
        for (e = 0; e < 2; e++)
        begin : g_ext
            // level mode follows the inverted pin; edge mode catches high then low
            assign ext_set[e] = at_state5_phase2_sample_point && (edge_sel[e] ? (pin_prev_reg[e] && !pin[e])
                                                        : !pin[e]);                // R16 R17
            // level mode drops with the pin; edge mode is cleared by vectoring
            assign ext_clr[e] = (at_state5_phase2_sample_point && !edge_sel[e] && pin[e]) ||
                                (take && edge_sel[e] && (pick_src == 3'(2 * e))); // R13
        end
    endgenerate

    // set and clear masks; a hardware set always beats any clear
    wire logic [7:0] tc_set;
    wire logic [7:0] tc_clr;
    wire logic [7:0] sc_set;
    wire logic [7:0] t2_set;
    wire logic [7:0] tc_sw;

    assign tc_set = ({7'h0, ext_set[0]} << TC_EXT0_FLAG) | ({7'h0, ext_set[1]} << TC_EXT1_FLAG)
                  | ({7'h0, flag_set.timer0_ovf} << TC_TF0)
                  | ({7'h0, flag_set.timer1_ovf} << TC_TF1);
    assign tc_clr = ({7'h0, ext_clr[0]} << TC_EXT0_FLAG) | ({7'h0, ext_clr[1]} << TC_EXT1_FLAG)
                  | ({7'h0, take && (pick_src == SRC_T0)} << TC_TF0)   // R13
                  | ({7'h0, take && (pick_src == SRC_T1)} << TC_TF1);  // R13
    assign sc_set = ({7'h0, flag_set.rx_done} << SC_RX) | ({7'h0, flag_set.tx_done} << SC_TX);
    assign t2_set = ({7'h0, flag_set.timer2_ovf} << T2_TF2)
                  | ({7'h0, flag_set.timer2_ext} << T2_TIMER2_EXTERNAL_FLAG);
    assign tc_sw  = wr_tc ? wdata : tc_reg;

    // flag registers; serial and timer2 flags only cleared by software
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            tc_reg <= RST_REG8;
            sc_reg <= RST_REG8;
            t2_reg <= RST_REG8;
        end
        else
        begin
            tc_reg <= tc_set | (tc_sw & ~tc_clr);
            sc_reg <= sc_set | (wr_sc ? wdata : sc_reg); // R13
            t2_reg <= t2_set | (wr_t2 ? wdata : t2_reg); // R13
        end

    // enable and priority registers
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            ie_reg <= RST_REG8;
            ip_reg <= RST_REG8; // R2
        end
        else
        begin
            if (wr_ie)
                ie_reg <= wdata;
            if (wr_ip)
                ip_reg <= wdata; // R1
        end

    // sampling and polling snapshots
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            pin_prev_reg <= 2'b11;
            samp_reg     <= 5'h00;
            poll_reg     <= 6'h00;
        end
        else
        begin
            if (at_state5_phase2_sample_point)
            begin
                pin_prev_reg <= pin;            // R17
                samp_reg     <= src_flag[4:0];  // R6
            end
            if (at_state2_phase2_point)
                poll_reg[SRC_T2] <= src_flag[SRC_T2]; // R22
            if (at_end)
                poll_reg[4:0] <= samp_reg;      // R6 R9
        end

    // in-progress levels: set by a call, cleared by the return instruction only
    wire logic [1:0] ip_clr;
    wire logic [1:0] ip_set;

    assign ip_clr = !isr_exit_instruction ? 2'b00 :
                    inprog_reg[1]         ? 2'b10 : 2'b01; // R14 R15
    assign ip_set = !take ? 2'b00 : (use_hi ? 2'b10 : 2'b01); // R23

    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            inprog_reg <= 2'b00;
        else
            inprog_reg <= (inprog_reg & ~ip_clr) | ip_set; // R23 R14

    // blocking by the instruction that accessed control or returned
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            cur_blk_reg <= 1'b0;
        else if (blk_evt)
            cur_blk_reg <= 1'b1;                // R8
        else if (at_end && instr_last_cycle)
            cur_blk_reg <= 1'b0;                // R8

    // call request to the core, which pushes only the program counter
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            call_reg <= 1'b0;
            info_reg <= '{addr: RESET_VEC, level: 1'b0, src: 3'h0}; // R12
        end
        else
        begin
            call_reg <= take; // R10
            if (take)
                info_reg <= '{addr: vec_of(pick_src), level: use_hi, src: pick_src}; // R11 R12
        end

    // outputs
    assign hardware_subroutine_call = call_reg;
    assign call_info                = info_reg;
    assign cycle_end                = at_end;
    assign in_progress              = inprog_reg;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // a call always comes one clock after a machine-cycle end
    property p_call_timing;
        hardware_subroutine_call |-> $past(at_end) && (phase_reg == 4'h0);
    endproperty
    a_call_timing: assert property (p_call_timing) // R6
        else $error("call not aligned to machine cycle end");

    // high level in progress is never preempted
    property p_high_no_preempt;
        hardware_subroutine_call |-> !$past(inprog_reg[1]);
    endproperty
    a_high_no_preempt: assert property (p_high_no_preempt) // R3
        else $error("call taken while high level in progress");

    // a low-level call needs no routine in progress
    property p_low_needs_idle;
        hardware_subroutine_call && !call_info.level |-> $past(inprog_reg) == 2'b00;
    endproperty
    a_low_needs_idle: assert property (p_low_needs_idle) // R3
        else $error("low level call nested");

    // calls only at instruction end and outside a blocking instruction
    property p_blocked;
        hardware_subroutine_call |-> $past(instr_last_cycle) && !$past(cur_blk_reg);
    endproperty
    a_blocked: assert property (p_blocked) // R7
        else $error("call while blocked");

    // vector address matches source
    property p_vector;
        hardware_subroutine_call |-> call_info.addr == 16'h0003 + {10'h0, call_info.src, 3'h0};
    endproperty
    a_vector: assert property (p_vector) // R11
        else $error("wrong vector address");

    // a call marks its level in progress at the same edge
    property p_level_mark;
        hardware_subroutine_call |-> in_progress[call_info.level];
    endproperty
    a_level_mark: assert property (p_level_mark) // R23
        else $error("in-progress bit not held");

    // plain return never changes in-progress state
    property p_plain_ret;
        plain_subroutine_exit && !isr_exit_instruction && !take |=>
            inprog_reg == $past(inprog_reg);
    endproperty
    a_plain_ret: assert property (p_plain_ret) // R15
        else $error("plain return changed in-progress");

    // vectoring to timer 1 clears its flag unless set again
    property p_t1_clear;
        take && (pick_src == SRC_T1) && !flag_set.timer1_ovf && !wr_tc |=> !tc_reg[TC_TF1];
    endproperty
    a_t1_clear: assert property (p_t1_clear) // R13
        else $error("timer 1 flag not cleared");

    // edge mode: high then low sample sets the request
    property p_edge_set;
        at_state5_phase2_sample_point && tc_reg[TC_IT0] && pin_prev_reg[0] && !ext0_pin |=> tc_reg[TC_EXT0_FLAG];
    endproperty
    a_edge_set: assert property (p_edge_set) // R17
        else $error("edge not caught");

    // a higher level request is chosen over a lower one
    property p_higher_first;
        take && hi_any && !inprog_reg[1] |=> call_info.level;
    endproperty
    a_higher_first: assert property (p_higher_first) // R4
        else $error("lower level chosen");

endmodule

`default_nettype wire

// ---- design/tlv_pkg.sv ----
// tlv_pkg: constants and carrier types of the two-level vectored interrupt unit
// assumes one 125 MHz clock; a machine cycle is twelve clocks (six states of two phases)
package tlv_pkg;

    // machine-cycle timing, in clocks from the start of state 1 phase 1
    localparam int         MC_CLKS  = 12;     // clocks per machine cycle
    localparam logic [3:0] PH_STATE2_PHASE2_POINT  = 4'h3;   // state2_phase2_point
    localparam logic [3:0] PH_STATE5_PHASE2_SAMPLE_POINT  = 4'h9;   // state5_phase2_sample_point
    localparam logic [3:0] PH_LAST  = 4'(MC_CLKS - 1);

    // register byte offsets on the bus (low address byte decoded)
    localparam logic [7:0] ADDR_TIMER_CTRL  = 8'h88;
    localparam logic [7:0] ADDR_SERIAL_CTRL = 8'h98;
    localparam logic [7:0] ADDR_INT_ENABLE  = 8'ha8;
    localparam logic [7:0] ADDR_PRIORITY    = 8'hb8;
    localparam logic [7:0] ADDR_TIMER2_CTRL = 8'hc8;
    localparam logic [7:0] ADDR_STATUS      = 8'hd0;

    // values after reset
    localparam logic [7:0]  RST_REG8   = 8'h00;
    localparam logic [15:0] RESET_VEC  = 16'h0000;

    // field positions
    localparam int IE_GLOBAL    = 7;   // global enable in interrupt_enable_reg
    localparam int TC_IT0       = 0;   // ext0_edge_select
    localparam int TC_EXT0_FLAG = 1;   // ext0_request_flag
    localparam int TC_IT1       = 2;   // ext1_edge_select
    localparam int TC_EXT1_FLAG = 3;   // ext1_request_flag
    localparam int TC_TF0       = 5;   // timer0_overflow_flag
    localparam int TC_TF1       = 7;   // timer1_overflow_flag
    localparam int SC_RX        = 0;   // rx_done_flag
    localparam int SC_TX        = 1;   // tx_done_flag
    localparam int T2_TIMER2_EXTERNAL_FLAG      = 6;   // timer2_external_flag
    localparam int T2_TF2       = 7;   // timer2_overflow_flag

    // sources in polling order, highest first
    localparam int         SRC_COUNT = 6;
    localparam logic [2:0] SRC_EXT0  = 3'h0;
    localparam logic [2:0] SRC_T0    = 3'h1;
    localparam logic [2:0] SRC_EXT1  = 3'h2;
    localparam logic [2:0] SRC_T1    = 3'h3;
    localparam logic [2:0] SRC_SER   = 3'h4;
    localparam logic [2:0] SRC_T2    = 3'h5;

    // vector of source n is VEC_BASE + 8*n
    localparam logic [15:0] VEC_BASE = 16'h0003;

    // hardware set pulses from timer and serial units
    typedef struct packed {
        logic timer0_ovf;
        logic timer1_ovf;
        logic timer2_ovf;
        logic timer2_ext;
        logic rx_done;
        logic tx_done;
    } tlv_evt_s;

    // call request handed to the core sequencer
    typedef struct packed {
        logic [15:0] addr;    // vector address
        logic        level;   // 1 = high priority level
        logic [2:0]  src;     // source index
    } tlv_call_s;

endpackage

// ---- design/tlv_prio_pick.sv ----
// tlv_prio_pick: fixed-order pick of the lowest-numbered active request
// assumes bit 0 is the highest position in the polling order
`timescale 1ns/10ps
`default_nettype none

module tlv_prio_pick
#(
    parameter int N = 6,   // number of request lines
    parameter int W = 3    // width of the index
)
(
    input  wire logic [N-1:0] req,
    output logic              any,
    output logic [W-1:0]      idx
);

    // any request at all
    assign any = |req;

    // scan from lowest order upward so the highest order wins
    always_comb
    begin
        idx = '0;
        for (int i = N - 1; i >= 0; i--)
            if (req[i])
                idx = W'(i);
    end

endmodule

`default_nettype wire

// ---- verif/tlv_core_model.sv ----
// tlv_core_model: stand-in for the core sequencer beside the interrupt unit
// assumes the bench steers stalls and returns; cycle_end comes from the unit
`timescale 1ns/10ps
`default_nettype none

module tlv_core_model
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic cycle_end,             // last clock of a machine cycle
    input  wire logic stall,                 // keep the instruction open
    input  wire logic ret_go,                // run a service return
    input  wire logic plain_go,              // run an ordinary return
    output logic      instr_last_cycle,
    output logic      isr_exit_instruction,
    output logic      plain_subroutine_exit
);
    // instruction end is a level that only changes between machine cycles
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            instr_last_cycle      <= 1'b1;
            isr_exit_instruction  <= 1'b0;
            plain_subroutine_exit <= 1'b0;
        end
        else
        begin
            if (cycle_end)
                instr_last_cycle <= !stall;
            isr_exit_instruction  <= ret_go;
            plain_subroutine_exit <= plain_go;
        end
    end
endmodule
`default_nettype wire

// ---- verif/tlv_intr_unit_tb_top.sv ----
// tlv_intr_unit_tb_top: self-checking bench for the interrupt unit
// assumes the unit and the core model; the bench also plays the pin requesters
`timescale 1ns/10ps
`default_nettype none

module tlv_intr_unit_tb_top
    import tlv_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, ext0_pin, ext1_pin;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, rd;
    logic        stall, ret_go, plain_go;
    tlv_evt_s    flag_set;
    wire logic [31:0] hrdata;
    wire logic   hreadyout, hresp, call, ilc, iex, pex, cyc;
    wire tlv_call_s   call_info;
    wire logic [1:0]  in_progress;
    int          fail_count, n_tests, i;
    // per source: vector, set pulse, flag register, value after vectoring
    logic [15:0] vecs [6] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b};
    logic [5:0]  evts [6] = '{6'h00, 6'h20, 6'h00, 6'h10, 6'h02, 6'h04};
    logic [7:0]  fregs [6] = '{ADDR_TIMER_CTRL, ADDR_TIMER_CTRL, ADDR_TIMER_CTRL,
                               ADDR_TIMER_CTRL, ADDR_SERIAL_CTRL, ADDR_TIMER2_CTRL};
    logic [7:0]  fexp [6] = '{8'h05, 8'h05, 8'h05, 8'h05, 8'h01, 8'h40};
    logic [7:0]  rsts [6] = '{8'h88, 8'h98, 8'ha8, 8'hb8, 8'hc8, 8'hd0};

    tlv_intr_unit dut
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ext0_pin(ext0_pin), .ext1_pin(ext1_pin), .flag_set(flag_set),
        .instr_last_cycle(ilc), .isr_exit_instruction(iex),
        .plain_subroutine_exit(pex), .hardware_subroutine_call(call),
        .call_info(call_info), .cycle_end(cyc), .in_progress(in_progress)
    );

    tlv_core_model core
    (
        .hclk(hclk), .hresetn(hresetn), .cycle_end(cyc), .stall(stall),
        .ret_go(ret_go), .plain_go(plain_go), .instr_last_cycle(ilc),
        .isr_exit_instruction(iex), .plain_subroutine_exit(pex)
    );

    // free-running bus clock
    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // verdict and end of run
    task close_out;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one comparison
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // wait for hready high at a rising edge, bounded
    task rdy;
        int k;
        k = 0;
        do
        begin
            @(posedge hclk);
            k++;
        end
        while (hreadyout !== 1'b1 && k < 20);
        if (hreadyout !== 1'b1)
        begin
            chk(32'(hreadyout), 32'h1);
            close_out;
        end
    endtask

    // single word transfer: address phase, then data phase
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        rdy;
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        rdy;
        d = hrdata;
        chk(32'(hresp), 32'h0);
    endtask

    // one-clock set pulse from the timer and serial units
    task evt(input logic [5:0] e);
        @(posedge hclk);
        flag_set <= e;
        @(posedge hclk);
        flag_set <= '0;
    endtask

    // service return issued by the core
    task ret;
        @(posedge hclk);
        ret_go <= 1'b1;
        @(posedge hclk);
        ret_go <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask

    // wait for a vector call and check where it goes and which level is busy
    task wcall(input logic [15:0] va, input logic [1:0] ip);
        int k;
        k = 0;
        while (call !== 1'b1 && k < 80)
        begin
            @(negedge hclk);
            k++;
        end
        if (call !== 1'b1)
        begin
            chk(32'(call), 32'h1);
            close_out;
        end
        else
        begin
            chk(32'(call_info.addr), 32'(va));
            chk(32'(in_progress), 32'(ip));
            chk(32'(call_info.level), 32'(ip[1]));
            chk(32'(call_info.src), 32'((va - 16'h0003) >> 3));
        end
    endtask

    // no call may appear over n clocks
    task no_call(input int n);
        int k;
        logic seen;
        seen = 1'b0;
        for (k = 0; k < n; k++)
        begin
            @(negedge hclk);
            if (call !== 1'b0)
                seen = 1'b1;
        end
        chk(32'(seen), 32'h0);
    endtask

    // main sequence
    initial
    begin
        fail_count = 0;
        n_tests = 0;
        {hresetn, hsel, htrans, haddr, hwrite, hwdata} = '0;
        hsize = 3'b010;
        {ext0_pin, ext1_pin} = 2'b11;
        flag_set = '0;
        {stall, ret_go, plain_go} = 3'b000;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rsts[j])
        begin
            bus(1'b0, rsts[j], 32'h0, rd);
            chk(rd, 32'h0);
        end
        bus(1'b1, ADDR_PRIORITY, 32'hffffff3f, rd);
        bus(1'b0, ADDR_PRIORITY, 32'h0, rd);
        chk(rd, 32'h3f);
        bus(1'b1, ADDR_PRIORITY, 32'h0, rd);
        bus(1'b1, ADDR_TIMER_CTRL, 32'h05, rd);
        // each source alone, low level, external pins in edge mode
        for (i = 0; i < 6; i++)
        begin
            bus(1'b1, ADDR_INT_ENABLE, 32'h80 | (32'h1 << i), rd);
            @(posedge hclk);
            ext0_pin <= (i != 0);
            ext1_pin <= (i != 2);
            evt(evts[i]);
            wcall(vecs[i], 2'b01);
            @(posedge hclk);
            {ext0_pin, ext1_pin} <= 2'b11;
            bus(1'b0, fregs[i], 32'h0, rd);
            chk(rd, {24'h0, fexp[i]});
            @(posedge hclk);
            plain_go <= 1'b1;
            @(posedge hclk);
            plain_go <= 1'b0;
            repeat (3) @(posedge hclk);
            chk(32'(in_progress), 32'h1);
            bus(1'b1, fregs[i], {24'h0, (i < 4) ? 8'h05 : 8'h00}, rd);
            ret;
            chk(32'(in_progress), 32'h0);
        end
        // timer1 high, timer0 low: level wins, nesting per level
        bus(1'b1, ADDR_PRIORITY, 32'h08, rd);
        bus(1'b1, ADDR_INT_ENABLE, 32'h8a, rd);
        evt(6'h30);
        wcall(16'h001b, 2'b10);
        no_call(40);
        ret;
        wcall(16'h000b, 2'b01);
        evt(6'h10);
        wcall(16'h001b, 2'b11);
        ret;
        chk(32'(in_progress), 32'h1);
        ret;
        // same level: fixed polling order
        bus(1'b1, ADDR_PRIORITY, 32'h0, rd);
        evt(6'h30);
        wcall(16'h000b, 2'b01);
        ret;
        wcall(16'h001b, 2'b01);
        ret;
        // level mode ext1 held off by an open instruction, then withdrawn
        bus(1'b1, ADDR_TIMER_CTRL, 32'h01, rd);
        bus(1'b1, ADDR_INT_ENABLE, 32'h84, rd);
        @(posedge hclk);
        stall <= 1'b1;
        ext1_pin <= 1'b0;
        no_call(40);
        @(posedge hclk);
        ext1_pin <= 1'b1;
        repeat (30) @(posedge hclk);
        stall <= 1'b0;
        no_call(40);
        @(posedge hclk);
        ext1_pin <= 1'b0;
        wcall(16'h0013, 2'b01);
        @(posedge hclk);
        ext1_pin <= 1'b1;
        repeat (24) @(posedge hclk);
        ret;
        no_call(40);
        close_out;
    end
endmodule
`default_nettype wire
